// ===== bench/cfc_codec_props_props.sv
// Port assertions for the frame codec.
`timescale 1ns/1ps
`default_nettype none
module cfc_codec_props (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Watched ports.
	input wire logic link_rx_frame,
	input wire logic link_tx_data_q,
	input wire logic link_tx_en_q,
	input wire logic rx_byte_valid_q,
	input wire logic rx_last_q,
	input wire logic tx_start,
	input wire logic [5:0] tx_len,
	input wire logic tx_busy_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// A send request that must be taken.
	sequence s_take;
		tx_start && !tx_busy_q && !link_rx_frame && tx_len >= 6'h01 && tx_len <= 6'h20;
	endsequence
	// Busy, then the frame opens with a high start bit.
	sequence s_lead;
		tx_busy_q ##[1:40] ($rose(link_tx_en_q) && link_tx_data_q);
	endsequence
	AST_ACCEPT: assert property (s_take |=> s_lead) else $error("send not started");
	AST_REFUSE: assert property (tx_start && !tx_busy_q && (tx_len == 6'h00 || tx_len > 6'h20)
		|=> !tx_busy_q) else $error("bad length taken");
	AST_EN_BUSY: assert property (link_tx_en_q |-> tx_busy_q) else $error("send not busy");
	AST_STOP: assert property ($fell(link_tx_en_q) |-> ##[0:2] !tx_busy_q) else $error("busy stays");
	AST_BIT_HOLD: assert property (link_tx_en_q && $changed(link_tx_data_q)
		|=> $stable(link_tx_data_q) [*4]) else $error("bit too short");
	AST_QUIET: assert property (link_rx_frame [*8] |-> !rx_byte_valid_q) else $error("early byte");
	AST_BURST: assert property (rx_byte_valid_q && !rx_last_q |=> rx_byte_valid_q) else $error("gap");
	AST_LAST: assert property (rx_last_q |-> rx_byte_valid_q ##1 !rx_byte_valid_q) else $error("last");
endmodule // cfc_codec_props
bind cfc_frame_codec cfc_codec_props i_props (.sys_clk(sys_clk), .rst(rst),
	.link_rx_frame(link_rx_frame), .link_tx_data_q(link_tx_data_q), .link_tx_en_q(link_tx_en_q),
	.rx_byte_valid_q(rx_byte_valid_q), .rx_last_q(rx_last_q), .tx_start(tx_start),
	.tx_len(tx_len), .tx_busy_q(tx_busy_q));
`default_nettype wire

// ===== bench/cfc_frame_codec_tb.sv
// Self-checking bench for the frame codec.
`timescale 1ns/1ps
`default_nettype none
module cfc_frame_codec_tb;
	logic sys_clk, rst, tx_start, wr_en;
	wire link_clk, link_rx_frame, link_rx_data, link_tx_data_q, link_tx_en_q;
	wire rx_byte_valid_q, rx_last_q, tx_busy_q;
	wire [7:0] rx_byte_q;
	logic [3:0] tx_first_page, wr_page;
	logic [5:0] tx_len;
	logic [31:0] wr_data;
	logic [15:0] rnd = 16'hE49E;
	logic [7:0] mem [0:15][0:3] = '{default: 8'h00};
	logic [7:0] got[$];
	int num_errors, check_count;
	int last_at;
	cfc_frame_codec i_dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
		.link_rx_frame(link_rx_frame), .link_rx_data(link_rx_data), .link_tx_data_q(link_tx_data_q),
		.link_tx_en_q(link_tx_en_q), .rx_byte_valid_q(rx_byte_valid_q), .rx_byte_q(rx_byte_q),
		.rx_last_q(rx_last_q), .tx_start(tx_start), .tx_first_page(tx_first_page), .tx_len(tx_len),
		.tx_busy_q(tx_busy_q), .wr_en(wr_en), .wr_page(wr_page), .wr_data(wr_data));
	cfc_reader_model i_rdr (.link_clk(link_clk), .link_rx_frame(link_rx_frame),
		.link_rx_data(link_rx_data), .link_tx_data_q(link_tx_data_q), .link_tx_en_q(link_tx_en_q));
	// Clock at 125 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Collects replayed bytes away from the launching edge, and where the last flag stood.
	always @(negedge sys_clk) begin
		if (rx_last_q === 1'b1)
			last_at = got.size();
		if (rx_byte_valid_q === 1'b1)
			got.push_back(rx_byte_q);
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Sends random bytes; damaged or overlong frames must give nothing.
	task automatic rx_case(input int n, input int err);
		logic [7:0] d[$];
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			d.push_back(rnd[7:0]);
		end
		got.delete();
		last_at = -1;
		i_rdr.send(d, err);
		repeat (40) @(negedge sys_clk);
		if (err != 0 || n > 16)
			d.delete();
		chk_val("rx count", 16'(d.size()), 16'(got.size()));
		chk_val("rx last", 16'(d.size() - 1), 16'(last_at));
		foreach (d[i])
			chk_val("rx byte", {8'h00, d[i]}, {8'h00, got[i]});
	endtask
	// Requests pages and checks the bits on the link.
	task automatic tx_case(input logic [3:0] pg, input logic [5:0] n);
		logic [7:0] d[$];
		logic b[$];
		for (int i = 0; i < n; i++)
			d.push_back(mem[(pg + i / 4) % 16][i % 4]);
		tx_first_page = pg;
		tx_len = n;
		tx_start = 1'b1;
		@(negedge sys_clk);
		tx_start = 1'b0;
		chk_val("busy", {15'h0000, n >= 6'h01 && n <= 6'h20}, {15'h0000, tx_busy_q});
		if (tx_busy_q === 1'b1) begin
			i_rdr.listen();
			i_rdr.code(d, b);
			chk_val("tx bits", 16'(b.size()), 16'(i_rdr.got_q.size()));
			foreach (b[i])
				chk_val("tx bit", {15'h0000, b[i]}, {15'h0000, i_rdr.got_q[i]});
		end
		@(negedge sys_clk);
	endtask
	// Main sequence.
	initial begin
		rst = 1'b1;
		tx_start = 1'b0;
		tx_first_page = 4'h0;
		tx_len = 6'h00;
		wr_en = 1'b0;
		wr_page = 4'h0;
		wr_data = 32'h00000000;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		for (int p = 0; p < 15; p++) begin
			rnd = lfsr(rnd);
			wr_data = {rnd, ~rnd};
			wr_page = p[3:0];
			wr_en = 1'b1;
			for (int k = 0; k < 4 && p < 14; k++)
				mem[p][k] = wr_data[8*k +: 8];
			@(negedge sys_clk);
		end
		wr_en = 1'b0;
		rx_case(16, 0);
		rx_case(17, 0);
		rx_case(1, 0);
		rx_case(4, 1);
		rx_case(4, 2);
		rx_case(4, 3);
		tx_case(4'hC, 6'h20);
		tx_case(4'h4, 6'h05);
		tx_case(4'h0, 6'h00);
		tx_case(4'h0, 6'h21);
		finish_test();
	end
	// Watchdog: the run needs about 75 us, so 0.4 ms means a hang.
	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
endmodule // cfc_frame_codec_tb
`default_nettype wire

// ===== bench/cfc_reader_model.sv
// Reader model: sends frames to the card and collects its answer.
`timescale 1ns/1ps
`default_nettype none
module cfc_reader_model (
	// Link to the card.
	output logic link_clk,
	output logic link_rx_frame,
	output logic link_rx_data,
	// Card answer.
	input wire logic link_tx_data_q,
	input wire logic link_tx_en_q
);
	logic got_q[$];
	// The bit clock stands still except while a frame is sent or the card's answer is clocked.
	initial begin
		link_clk = 1'b0;
		link_rx_frame = 1'b0;
		link_rx_data = 1'b0;
	end
	// Codes bytes as start bit, LSB-first bytes with parity, CRC low byte first.
	function automatic void code(input logic [7:0] d[$], output logic b[$]);
		logic [15:0] c;
		c = 16'h6363;
		foreach (d[i])
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ d[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
		d.push_back(c[7:0]);
		d.push_back(c[15:8]);
		b = {1'b1};
		foreach (d[i]) begin
			for (int k = 0; k < 8; k++)
				b.push_back(d[i][k]);
			b.push_back(~^d[i]);
		end
	endfunction
	// One 80 ns bit period; the card's bit is taken 62 ns in, 20 ns after the falling edge, clear of its change.
	// The rising edge falls between system clock edges, so sampling has no race.
	task automatic tick(input logic v);
		link_rx_data = v;
		#22 link_clk = 1'b1;
		#20 link_clk = 1'b0;
		#20;
		if (link_tx_en_q)
			got_q.push_back(link_tx_data_q);
		#18;
	endtask
	// Sends a frame; err 1 spoils a parity, 2 the start bit, 3 the CRC.
	task automatic send(input logic [7:0] d[$], input int err);
		logic b[$];
		code(d, b);
		if (err == 1)
			b[9] = ~b[9];
		if (err == 2)
			b[0] = 1'b0;
		if (err == 3) begin
			b[$] = ~b[$];
			b[$-1] = ~b[$-1];
		end
		link_rx_frame = 1'b1;
		#40;
		foreach (b[i])
			tick(b[i]);
		link_rx_frame = 1'b0;
		link_rx_data = ~link_rx_data;
	endtask
	// Clocks the card's answer, changing the idle data line every bit.
	task automatic listen();
		int n;
		n = 0;
		got_q.delete();
		do begin
			tick(~link_rx_data);
			n++;
		end while ((link_tx_en_q || got_q.size() == 0) && n < 400);
	endtask
endmodule // cfc_reader_model
`default_nettype wire

// ===== logic/cfc_consts.vh
// Constants for the contactless frame codec and its page store.
// Overview of operation
// - Every frame in either direction opens with one start bit.
// - Each byte is followed by an odd parity bit, checked on reception.
// - Bytes go least significant bit first, lowest address byte first.
// - Received frames up to 163 bits (16 data bytes plus CRC) are accepted.
// - Sent frames stay within 307 bits: at most 32 data bytes plus CRC.
// - Multi-byte parameters travel least significant byte first.
// - Memory replies send page bytes 0 to 3, then following pages alike.
// - Both directions run at 106 kbit/s derived from the 13.56 MHz carrier.
// - A 16-bit CRC guards each frame; frames failing any check are rejected.
// - The store holds 14 pages of four bytes, 448 bits in all.
// - Store split: 80 bits maker data, 16 lock bits, 32 OTP, 320 user.
`ifndef CFC_CONSTS_VH
`define CFC_CONSTS_VH

// Link timing.
`define CFC_CARRIER_KHZ 13560
`define CFC_BIT_DIV 128
`define CFC_BIT_RATE_KBPS 106

// Frame limits.
`define CFC_RX_MAX_BITS 8'hA3
`define CFC_RX_MAX_BYTES 18
`define CFC_TX_MAX_DATA 6'h20
`define CFC_TX_MAX_BITS 307
`define CFC_CRC_BYTES 5'h02
`define CFC_BITS_PER_BYTE 9
`define CFC_START_BIT_VAL 1'b1

// CRC_A.
`define CFC_CRC_PRESET 16'h6363
`define CFC_CRC_POLY 16'h8408

// Page store layout.
`define CFC_PAGES 4'hE
`define CFC_PAGE_BYTES 4
`define CFC_MFR_FIRST_PAGE 4'h0
`define CFC_MFR_BYTES 10
`define CFC_LOCK_PAGE 4'h2
`define CFC_LOCK_BYTE_LO 2
`define CFC_OTP_PAGE 4'h3
`define CFC_USER_FIRST_PAGE 4'h4
`define CFC_USER_LAST_PAGE 4'hD

`endif

// ===== logic/cfc_frame_codec.v
// Card-side frame builder and checker for the contactless link, with its page store.
`timescale 1ns/1ps
`default_nettype none
`include "cfc_consts.vh"

module cfc_frame_codec (
	// Clock and reset.
	input wire sys_clk,
	input wire rst,
	// Link pins, demodulated bit stream and bit clock from the carrier.
	input wire link_clk,
	input wire link_rx_frame,
	input wire link_rx_data,
	output reg link_tx_data_q,
	output reg link_tx_en_q,
	// Received payload, replayed after all checks pass.
	output reg rx_byte_valid_q,
	output reg [7:0] rx_byte_q,
	output reg rx_last_q,
	// Response request: send pages starting at a page.
	input wire tx_start,
	input wire [3:0] tx_first_page,
	input wire [5:0] tx_len,
	output reg tx_busy_q,
	// Page write port.
	input wire wr_en,
	input wire [3:0] wr_page,
	input wire [31:0] wr_data
);

	localparam [3:0] TX_IDLE = 4'b0001;
	localparam [3:0] TX_START = 4'b0010;
	localparam [3:0] TX_DATA = 4'b0100;
	localparam [3:0] TX_CRC = 4'b1000;

	// Advance CRC_A by one byte, bits taken least significant first.
	function [15:0] crc_a_byte;
		input [15:0] crc;
		input [7:0] data;
		integer i;
		reg [15:0] c;
		begin
			c = crc;
			for (i = 0; i < 8; i = i + 1) begin
				if (c[0] ^ data[i]) begin
					c = (c >> 1) ^ `CFC_CRC_POLY;
				end else begin
					c = c >> 1;
				end
			end
			crc_a_byte = c;
		end
	endfunction

	// Two-flop synchronisers for the link pins, a third stage for edges.
	reg clk_s1_q, clk_s2_q, clk_s3_q;
	reg frm_s1_q, frm_s2_q, frm_s3_q;
	reg dat_s1_q, dat_s2_q;
	wire bit_rise;
	wire frm_rise;
	wire frm_fall;

	always @(posedge sys_clk) begin
		if (rst) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			frm_s1_q <= 1'b0;
			frm_s2_q <= 1'b0;
			frm_s3_q <= 1'b0;
			dat_s1_q <= 1'b0;
			dat_s2_q <= 1'b0;
		end else begin
			clk_s1_q <= link_clk;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			frm_s1_q <= link_rx_frame;
			frm_s2_q <= frm_s1_q;
			frm_s3_q <= frm_s2_q;
			dat_s1_q <= link_rx_data;
			dat_s2_q <= dat_s1_q;
		end
	end

	// Each rising bit clock edge is one bit at the carrier-derived rate.
	assign bit_rise = clk_s2_q & ~clk_s3_q;
	assign frm_rise = frm_s2_q & ~frm_s3_q;
	assign frm_fall = ~frm_s2_q & frm_s3_q;

	// Receive path state.
	reg [7:0] rx_bits_q;
	reg [3:0] rx_pos_q;
	reg [4:0] rx_nbytes_q;
	reg [7:0] rx_sh_q;
	reg [15:0] rx_crc_q;
	reg rx_err_q;
	reg [7:0] rx_buf [0:`CFC_RX_MAX_BYTES-1];
	reg rx_replay_q;
	reg [4:0] rx_rd_q;
	reg [4:0] rx_plen_q;
	wire rx_ok;

	// The frame passes only with whole bytes, a data byte, good parity and CRC residue zero.
	assign rx_ok = !rx_err_q && (rx_pos_q == 4'h0) &&
		(rx_nbytes_q > 5'd2) && (rx_crc_q == 16'h0000);

	// Bit collection and checking while the frame strobe is high.
	always @(posedge sys_clk) begin
		if (rst) begin
			rx_bits_q <= 8'h00;
			rx_pos_q <= 4'h0;
			rx_nbytes_q <= 5'h00;
			rx_sh_q <= 8'h00;
			rx_crc_q <= `CFC_CRC_PRESET;
			rx_err_q <= 1'b0;
		end else if (frm_rise) begin
			rx_bits_q <= 8'h00;
			rx_pos_q <= 4'h0;
			rx_nbytes_q <= 5'h00;
			rx_crc_q <= `CFC_CRC_PRESET;
			rx_err_q <= 1'b0;
		end else if (frm_s2_q && bit_rise && !tx_busy_q) begin
			if (rx_bits_q < 8'hFF) begin
				rx_bits_q <= rx_bits_q + 8'h01;
			end
			if (rx_bits_q >= `CFC_RX_MAX_BITS) begin
				rx_err_q <= 1'b1;
			end else if (rx_bits_q == 8'h00) begin
				if (dat_s2_q != `CFC_START_BIT_VAL) begin
					rx_err_q <= 1'b1;
				end
			end else if (rx_pos_q < 4'h8) begin
				rx_sh_q <= {dat_s2_q, rx_sh_q[7:1]};
				rx_pos_q <= rx_pos_q + 4'h1;
			end else begin
				if (dat_s2_q != ~^rx_sh_q) begin
					rx_err_q <= 1'b1;
				end
				rx_buf[rx_nbytes_q] <= rx_sh_q;
				rx_crc_q <= crc_a_byte(rx_crc_q, rx_sh_q);
				rx_nbytes_q <= rx_nbytes_q + 5'h01;
				rx_pos_q <= 4'h0;
			end
		end
	end

	// Replay of an accepted payload, CRC bytes stripped; rejected frames vanish.
	always @(posedge sys_clk) begin
		if (rst) begin
			rx_replay_q <= 1'b0;
			rx_rd_q <= 5'h00;
			rx_plen_q <= 5'h00;
			rx_byte_valid_q <= 1'b0;
			rx_byte_q <= 8'h00;
			rx_last_q <= 1'b0;
		end else begin
			rx_byte_valid_q <= 1'b0;
			rx_last_q <= 1'b0;
			if (frm_fall && rx_ok) begin
				rx_replay_q <= 1'b1;
				rx_rd_q <= 5'h00;
				rx_plen_q <= rx_nbytes_q - `CFC_CRC_BYTES;
			end else if (rx_replay_q) begin
				rx_byte_valid_q <= 1'b1;
				rx_byte_q <= rx_buf[rx_rd_q];
				rx_last_q <= (rx_rd_q == rx_plen_q - 5'h01);
				rx_rd_q <= rx_rd_q + 5'h01;
				if (rx_rd_q == rx_plen_q - 5'h01) begin
					rx_replay_q <= 1'b0;
				end
			end
		end
	end

	// Transmit path state.
	reg [3:0] tx_st_q;
	reg [3:0] tx_page_q;
	reg [5:0] tx_len_q;
	reg [5:0] tx_idx_q;
	reg [3:0] tx_pos_q;
	reg [15:0] tx_crc_q;
	wire [31:0] page_word;
	wire [3:0] rd_page;
	reg [7:0] tx_byte;

	// Page of the byte now on the wire; the store answers well within one bit.
	assign rd_page = tx_page_q + {2'b00, tx_idx_q[3:2]} + {tx_idx_q[5:4], 2'b00};

	cfc_page_store u_store (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_page(wr_page),
		.wr_data(wr_data),
		.rd_page(rd_page),
		.rd_data_q(page_word)
	);

	// Byte on the wire: page byte 0 first, then CRC low byte, then high byte.
	always @* begin
		tx_byte = 8'h00;
		if (tx_st_q == TX_CRC) begin
			tx_byte = tx_idx_q[0] ? tx_crc_q[15:8] : tx_crc_q[7:0];
		end else begin
			case (tx_idx_q[1:0])
				2'b00: tx_byte = page_word[7:0];
				2'b01: tx_byte = page_word[15:8];
				2'b10: tx_byte = page_word[23:16];
				default: tx_byte = page_word[31:24];
			endcase
		end
	end

	// Frame sequencer, one bit per rising bit clock edge.
	always @(posedge sys_clk) begin
		if (rst) begin
			tx_st_q <= TX_IDLE;
			tx_page_q <= 4'h0;
			tx_len_q <= 6'h00;
			tx_idx_q <= 6'h00;
			tx_pos_q <= 4'h0;
			tx_crc_q <= `CFC_CRC_PRESET;
			link_tx_data_q <= 1'b0;
			link_tx_en_q <= 1'b0;
			tx_busy_q <= 1'b0;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					link_tx_en_q <= 1'b0;
					link_tx_data_q <= 1'b0;
					if (tx_start && !frm_s2_q && (tx_len != 6'h00) &&
						(tx_len <= `CFC_TX_MAX_DATA)) begin
						tx_st_q <= TX_START;
						tx_page_q <= tx_first_page;
						tx_len_q <= tx_len;
						tx_idx_q <= 6'h00;
						tx_pos_q <= 4'h0;
						tx_crc_q <= `CFC_CRC_PRESET;
						tx_busy_q <= 1'b1;
					end
				end
				TX_START: begin
					if (bit_rise) begin
						link_tx_en_q <= 1'b1;
						link_tx_data_q <= `CFC_START_BIT_VAL;
						tx_st_q <= TX_DATA;
					end
				end
				TX_DATA, TX_CRC: begin
					if (bit_rise) begin
						if (tx_pos_q < 4'h8) begin
							link_tx_data_q <= tx_byte[tx_pos_q[2:0]];
							tx_pos_q <= tx_pos_q + 4'h1;
						end else if (tx_pos_q == 4'h8) begin
							link_tx_data_q <= ~^tx_byte;
							tx_pos_q <= 4'h0;
							tx_idx_q <= tx_idx_q + 6'h01;
							if (tx_st_q == TX_DATA) begin
								tx_crc_q <= crc_a_byte(tx_crc_q, tx_byte);
								if (tx_idx_q == tx_len_q - 6'h01) begin
									tx_st_q <= TX_CRC;
									tx_idx_q <= 6'h00;
								end
							end else if (tx_idx_q[0]) begin
								tx_pos_q <= 4'h9;
							end
						end else begin
							link_tx_en_q <= 1'b0;
							link_tx_data_q <= 1'b0;
							tx_busy_q <= 1'b0;
							tx_st_q <= TX_IDLE;
						end
					end
				end
				default: begin
					tx_st_q <= TX_IDLE;
				end
			endcase
		end
	end

endmodule // cfc_frame_codec
`default_nettype wire

// ===== logic/cfc_page_store.v
// Page-organised store of 14 four-byte pages with a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "cfc_consts.vh"

module cfc_page_store (
	// Clock and reset.
	input wire sys_clk,
	input wire rst,
	// Page write port.
	input wire wr_en,
	input wire [3:0] wr_page,
	input wire [31:0] wr_data,
	// Page read port.
	input wire [3:0] rd_page,
	output reg [31:0] rd_data_q
);

	// Pages 0-1 and byte 0-1 of page 2 hold maker data, bytes 2-3 of page 2 lock bits,
	// page 3 the OTP word and pages 4 to 13 user memory; byte 0 sits in bits 7:0.
	reg [31:0] mem [0:`CFC_PAGES-1];

	// Writes beyond the last page are ignored.
	always @(posedge sys_clk) begin
		if (wr_en && (wr_page < `CFC_PAGES)) begin
			mem[wr_page] <= wr_data;
		end
	end

	// Reads of absent pages return zero.
	always @(posedge sys_clk) begin
		if (rst) begin
			rd_data_q <= 32'h0000_0000;
		end else if (rd_page < `CFC_PAGES) begin
			rd_data_q <= mem[rd_page];
		end else begin
			rd_data_q <= 32'h0000_0000;
		end
	end

endmodule // cfc_page_store
`default_nettype wire
